// [rtl/atp_defines.svh]
`ifndef ATP_DEFINES_SVH
`define ATP_DEFINES_SVH

// Clock and reference rates, in Hz.
`define ATP_SYS_CLK_HZ      125000000
`define ATP_REF_1MHZ_HZ     1000000
`define ATP_REF_100KHZ_HZ   100000
`define ATP_EXT_CLK_MAX_HZ  10000000

// Cycles of sys_clk per reference tick, derived from the rates.
`define ATP_DIV_1MHZ        (`ATP_SYS_CLK_HZ / `ATP_REF_1MHZ_HZ)
`define ATP_DIV_100KHZ      (`ATP_SYS_CLK_HZ / `ATP_REF_100KHZ_HZ)

`define ATP_CNT_W           16
`define ATP_PAIRS           8
`define ATP_CHANNELS        16
`define ATP_CNT_ZERO        16'h0000
`define ATP_CNT_ONE         16'h0001
`define ATP_CNT_RESET       16'hffff
`define ATP_PRE_ZERO        11'h000
`define ATP_PRE_ONE         11'h001

// Positions of the pins inside the synchroniser vector.
`define ATP_PINS            4
`define ATP_PIN_TRIG        0
`define ATP_PIN_TRIG_EN     1
`define ATP_PIN_EV_CLK      2
`define ATP_PIN_EV_GATE     3
`define ATP_SYNC_ZERO       4'h0

// Channel number field that names the pair, and the pair reset value.
`define ATP_PAIR_MSB        3
`define ATP_PAIR_LSB        1
`define ATP_PAIRS_ZERO      8'h00

`endif

// [rtl/atp_pkg.sv]
package atp_pkg;

   typedef enum logic [1:0] {
      ATP_TRIG_SW    = 2'b00,
      ATP_TRIG_PACER = 2'b01,
      ATP_TRIG_EXT   = 2'b11
   } atp_trig_src_t;

   typedef enum logic {
      ATP_CLK_INT_100K = 1'b0,
      ATP_CLK_EXT_PIN  = 1'b1
   } atp_clk_sel_t;

endpackage

// [rtl/atp_stage_if.sv]
`timescale 1ns/1ps

interface atp_stage_if;
   logic        tick;
   logic [15:0] reload;
   logic        load;
   logic [15:0] count;
   logic        terminal;

   modport owner (
      output tick,
      output reload,
      output load,
      input  count,
      input  terminal
   );
   modport stage (
      input  tick,
      input  reload,
      input  load,
      output count,
      output terminal
   );
endinterface

// [rtl/atp_down_counter.sv]
`timescale 1ns/1ps
`include "atp_defines.svh"

// Reloading 16-bit divider stage: terminal pulses for one tick-cycle on wrap.
module atp_down_counter (
   input  wire logic sys_clk,
   input  wire logic rst,
   atp_stage_if.stage bus
);
   logic [15:0] cnt_q;
   logic        term_q;
   wire         at_one = (cnt_q <= `ATP_CNT_ONE);

   always_ff @(posedge sys_clk) begin
      if (rst || bus.load) begin
         cnt_q  <= bus.reload;
         term_q <= 1'b0;
      end else if (bus.tick) begin
         cnt_q  <= at_one ? bus.reload : cnt_q - `ATP_CNT_ONE;
         term_q <= at_one;
      end else begin
         term_q <= 1'b0;
      end
   end

   assign bus.count    = cnt_q;
   assign bus.terminal = term_q;
endmodule

// [rtl/atp_trigger_pacer.sv]
`timescale 1ns/1ps
`include "atp_defines.svh"

// Notes on behaviour
// - Event clock: external pin or internal 100 kHz
// - One pacer output pulse per pacer period
// - Pacer rising edge starts one conversion
// - Trigger gate high enables external trigger path
// - One conversion per gated external rising edge
// - Three 16-bit counters, pacer from 1 MHz
// - Second and third counters chain to 32 bits
// - Event counter counts edges, drives output pin
// - Event counter gate input enables counting
// - Per-pair input mode, other pairs stay unchanged
// - Channels pair even/odd, single or differential
module atp_trigger_pacer (
   input  wire logic                  sys_clk,
   input  wire logic                  rst,
   input  wire logic                  ext_trigger_in,
   input  wire logic                  ext_trigger_enable_in,
   input  wire logic                  event_counter_clock_in,
   input  wire logic                  event_counter_gate_in,
   input  wire atp_pkg::atp_trig_src_t trig_src,
   input  wire atp_pkg::atp_clk_sel_t event_clk_sel,
   input  wire logic                  pacer_run,
   input  wire logic [15:0]           pacer_div_lo,
   input  wire logic [15:0]           pacer_div_hi,
   input  wire logic                  pacer_load,
   input  wire logic [15:0]           event_reload,
   input  wire logic                  event_load,
   input  wire logic                  sw_trigger,
   input  wire logic [3:0]            cfg_channel,
   input  wire logic                  cfg_diff,
   input  wire logic                  cfg_write,
   output logic                       pacer_out,
   output logic                       event_counter_out,
   output logic [15:0]                event_count,
   output logic                       conv_start,
   output logic [7:0]                 pair_diff
);
   // Rising edge of a synchronised pin: its level now against one cycle ago.
   function automatic logic atp_rise(input logic now_lvl, input logic old_lvl);
      return now_lvl & ~old_lvl;
   endfunction

   // Prescaler end test, shared by both reference tick generators.
   function automatic logic atp_at_end(input logic [10:0] cnt,
                                       input logic [10:0] last);
      return cnt == last;
   endfunction

   // Trigger source decode, shared by the three start paths.
   function automatic logic atp_src_is(input atp_pkg::atp_trig_src_t src,
                                       input atp_pkg::atp_trig_src_t want);
      return src == want;
   endfunction

   // Two-flop synchronisers; only stage two is read by logic. The history
   // flops reset low, the idle level of every pin, so reset makes no edge.
   wire  [`ATP_PINS-1:0] pins_raw;
   logic [`ATP_PINS-1:0] sync1_q;
   logic [`ATP_PINS-1:0] sync2_q;
   logic [`ATP_PINS-1:0] prev_q;

   assign pins_raw[`ATP_PIN_TRIG]    = ext_trigger_in;
   assign pins_raw[`ATP_PIN_TRIG_EN] = ext_trigger_enable_in;
   assign pins_raw[`ATP_PIN_EV_CLK]  = event_counter_clock_in;
   assign pins_raw[`ATP_PIN_EV_GATE] = event_counter_gate_in;

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         sync1_q <= `ATP_SYNC_ZERO;
         sync2_q <= `ATP_SYNC_ZERO;
      end else begin
         sync1_q <= pins_raw;
         sync2_q <= sync1_q;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         prev_q <= `ATP_SYNC_ZERO;
      end else begin
         prev_q <= sync2_q;
      end
   end

   wire ext_trig_rise = atp_rise(sync2_q[`ATP_PIN_TRIG], prev_q[`ATP_PIN_TRIG]);
   wire ext_gate_lvl  = sync2_q[`ATP_PIN_TRIG_EN];
   wire ev_clk_rise   = atp_rise(sync2_q[`ATP_PIN_EV_CLK], prev_q[`ATP_PIN_EV_CLK]);
   wire ev_gate_lvl   = sync2_q[`ATP_PIN_EV_GATE];

   // Reference tick generators. A 10 MHz external clock is well inside the
   // sampling rate; faster edges would alias, which is the trade for one clock.
   wire  [10:0] last_1m   = 11'(`ATP_DIV_1MHZ - 1);
   wire  [10:0] last_100k = 11'(`ATP_DIV_100KHZ - 1);
   logic [10:0] pre1m_q;
   logic [10:0] pre100k_q;
   wire tick_1m   = atp_at_end(pre1m_q, last_1m);
   wire tick_100k = atp_at_end(pre100k_q, last_100k);

   always_ff @(posedge sys_clk) begin
      if (rst || tick_1m) begin
         pre1m_q <= `ATP_PRE_ZERO;
      end else begin
         pre1m_q <= pre1m_q + `ATP_PRE_ONE;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst || tick_100k) begin
         pre100k_q <= `ATP_PRE_ZERO;
      end else begin
         pre100k_q <= pre100k_q + `ATP_PRE_ONE;
      end
   end

   // Pacer: two cascaded 16-bit stages clocked from the 1 MHz reference.
   // The low stage's terminal is the high stage's tick, so the period is
   // the product of the two divisors in microseconds.
   atp_stage_if lo_if ();
   atp_stage_if hi_if ();
   atp_stage_if ev_if ();

   assign lo_if.tick   = tick_1m & pacer_run;
   assign lo_if.reload = pacer_div_lo;
   assign lo_if.load   = pacer_load;
   assign hi_if.tick   = lo_if.terminal;
   assign hi_if.reload = pacer_div_hi;
   assign hi_if.load   = pacer_load;

   // Event counter: gated, clocked by the selected source, counting down
   // from its reload so its terminal marks a full count of events.
   wire ev_ext_sel  = (event_clk_sel == atp_pkg::ATP_CLK_EXT_PIN);
   wire ev_src_tick = ev_ext_sel ? ev_clk_rise : tick_100k;
   assign ev_if.tick   = ev_src_tick & ev_gate_lvl;
   assign ev_if.reload = event_reload;
   assign ev_if.load   = event_load;

   atp_down_counter u_lo (
      .sys_clk (sys_clk),
      .rst     (rst),
      .bus     (lo_if)
   );

   atp_down_counter u_hi (
      .sys_clk (sys_clk),
      .rst     (rst),
      .bus     (hi_if)
   );

   atp_down_counter u_ev (
      .sys_clk (sys_clk),
      .rst     (rst),
      .bus     (ev_if)
   );

   wire        pacer_wrap = hi_if.terminal;
   wire        ev_wrap    = ev_if.terminal;
   wire [15:0] ev_count   = ev_if.count;

   // Conversion start: only the selected source may start a conversion;
   // the pacer and external paths give a single-cycle request, the software path follows the sw_trigger level.
   wire pacer_rise = pacer_wrap & pacer_run;
   wire pacer_sel  = atp_src_is(trig_src, atp_pkg::ATP_TRIG_PACER);
   wire ext_sel    = atp_src_is(trig_src, atp_pkg::ATP_TRIG_EXT);
   wire sw_sel     = atp_src_is(trig_src, atp_pkg::ATP_TRIG_SW);
   wire ext_start  = ext_sel & ext_gate_lvl & ext_trig_rise;
   wire pac_start  = pacer_sel & pacer_rise;
   wire sw_start   = sw_sel & sw_trigger;
   wire start_d    = ext_start | pac_start | sw_start;

   // Per-pair configuration: writing one channel touches only its pair bit.
   logic [7:0] pair_diff_q;
   wire  [2:0] cfg_pair = cfg_channel[`ATP_PAIR_MSB:`ATP_PAIR_LSB];

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         pair_diff_q <= `ATP_PAIRS_ZERO;
      end else if (cfg_write) begin
         pair_diff_q[cfg_pair] <= cfg_diff;
      end
   end

   // Every output is its own short register stage, so the pins see one
   // cycle of latency and never a decode glitch.
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         pacer_out <= 1'b0;
      end else begin
         pacer_out <= pacer_rise;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         event_counter_out <= 1'b0;
      end else begin
         event_counter_out <= ev_wrap;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         event_count <= `ATP_CNT_RESET;
      end else begin
         event_count <= ev_count;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         conv_start <= 1'b0;
      end else begin
         conv_start <= start_d;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         pair_diff <= `ATP_PAIRS_ZERO;
      end else begin
         pair_diff <= pair_diff_q;
      end
   end
endmodule

// [testbench/atp_trigger_pacer_properties.sv]
`timescale 1ns/1ps
module atp_trigger_pacer_properties (
   input wire logic                   sys_clk,
   input wire logic                   rst,
   input wire logic                   ext_trigger_in,
   input wire logic                   ext_trigger_enable_in,
   input wire atp_pkg::atp_trig_src_t trig_src,
   input wire logic                   pacer_run,
   input wire logic                   cfg_write,
   input wire logic                   pacer_out,
   input wire logic                   event_counter_out,
   input wire logic                   conv_start,
   input wire logic [7:0]             pair_diff
);
   wire ext = trig_src == atp_pkg::ATP_TRIG_EXT;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);
   sequence s_rise;
      $rose(ext_trigger_in) && ext && ext_trigger_enable_in && $past(ext_trigger_enable_in, 3);
   endsequence
   sequence s_shut;
      (ext && !ext_trigger_enable_in) [*5];
   endsequence
   a_ext_start: assert property (s_rise |-> ##3 conv_start) else $error("no start");
   a_gate_off: assert property (s_shut |-> !conv_start) else $error("gated start");
   a_ext_once: assert property (conv_start && ext |=> !conv_start) else $error("twin");
   a_pacer_conv: assert property (pacer_out && trig_src == atp_pkg::ATP_TRIG_PACER |-> conv_start)
      else $error("pacer no start");
   a_pacer_one: assert property (pacer_out |=> !pacer_out) else $error("pacer wide");
   a_pacer_idle: assert property (!pacer_run [*8] |-> !pacer_out) else $error("idle pulse");
   a_event_one: assert property (event_counter_out |=> !event_counter_out) else $error("wide");
   a_cfg_hold: assert property (!cfg_write ##1 !cfg_write |=> $stable(pair_diff))
      else $error("pair moved");
endmodule

// [testbench/atp_pin_source.sv]
`timescale 1ns/1ps
module atp_pin_source (
   input wire logic sys_clk,
   output logic     ext_trigger_in,
   output logic     event_counter_clock_in,
   output logic     ext_trigger_enable_in,
   output logic     event_counter_gate_in
);
   logic [1:0] p = 2'h0;
   logic [1:0] g = 2'h0;
   assign {event_counter_clock_in, ext_trigger_in} = p;
   assign {event_counter_gate_in, ext_trigger_enable_in} = g;
   // Index 0 is the trigger, 1 the event clock; h=7 keeps that clock under 10 MHz.
   task automatic pulse(input int i, input int h);
      @(posedge sys_clk) p[i] <= 1'b1;
      repeat (h) @(posedge sys_clk);
      p[i] <= 1'b0;
      repeat (h) @(posedge sys_clk);
   endtask
endmodule

// [testbench/adc_trigger_pacer_logic_test.sv]
`timescale 1ns/1ps
module adc_trigger_pacer_logic_test;
   logic sys_clk = 0, rst = 1, sw_trigger = 0, pacer_run = 0, pacer_load = 0, event_load = 0;
   logic cfg_diff = 0, cfg_write = 0, pacer_out, event_counter_out, conv_start;
   logic ext_trigger_in, ext_trigger_enable_in, event_counter_clock_in, event_counter_gate_in;
   atp_pkg::atp_trig_src_t trig_src = atp_pkg::ATP_TRIG_EXT;
   atp_pkg::atp_clk_sel_t  event_clk_sel = atp_pkg::ATP_CLK_EXT_PIN;
   logic [15:0] pacer_div_lo = 16'h0001, pacer_div_hi = 16'h0001, event_reload = 16'h0001;
   logic [15:0] event_count, c0;
   logic [3:0]  cfg_channel = 4'h0;
   logic [7:0]  pair_diff, pd = 8'h00;
   logic [31:0] seed = 32'h473fe799, r;
   int n_mismatch = 0, n_compared = 0, n_conv = 0, n_evt = 0, n_pac = 0, cyc = 0, last, per, k;
   int exp_q[$];
   logic ptrig = 0;
   atp_pin_source u_src (.sys_clk, .ext_trigger_in, .event_counter_clock_in,
      .ext_trigger_enable_in, .event_counter_gate_in);
   atp_trigger_pacer u_dut (.sys_clk, .rst, .ext_trigger_in, .ext_trigger_enable_in,
      .event_counter_clock_in, .event_counter_gate_in, .trig_src, .event_clk_sel, .pacer_run,
      .pacer_div_lo, .pacer_div_hi, .pacer_load, .event_reload, .event_load, .sw_trigger,
      .cfg_channel, .cfg_diff, .cfg_write, .pacer_out, .event_counter_out, .event_count,
      .conv_start, .pair_diff);
   initial forever #4 sys_clk = ~sys_clk;
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   task automatic chk(input string w, input logic [15:0] seen, input logic [15:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("wrong value %s expected %h seen %h", w, exp, seen);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk);
   endtask
   task automatic print_verdict();
      $display("compared %0d mismatched %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   always @(posedge sys_clk) begin
      cyc++;
      if (ext_trigger_in === 1'b1 && ptrig === 1'b0 && ext_trigger_enable_in === 1'b1 &&
          trig_src == atp_pkg::ATP_TRIG_EXT) exp_q.push_back(cyc + 3);
      ptrig = ext_trigger_in;
      if (exp_q.size() > 0 && exp_q[0] == cyc) begin
         void'(exp_q.pop_front());
         chk("ext model", 16'(conv_start), 16'h0001);
      end
      n_conv += int'(conv_start === 1'b1);
      n_evt += int'(event_counter_out === 1'b1);
      if (pacer_out === 1'b1) begin
         n_pac++;
         per = cyc - last;
         last = cyc;
      end
   end
   initial begin
      tick(40000);
      n_mismatch++;
      print_verdict();
   end
   initial begin
      tick(2);
      rst <= 0;
      u_src.g <= 2'h3;
      tick(4);
      k = rnd() % 4 + 1;
      repeat (k) u_src.pulse(0, 3);
      tick(4);
      chk("ext", 16'(n_conv), 16'(k));
      u_src.g <= 2'h2;
      tick(4);
      n_conv = 0;
      repeat (3) u_src.pulse(0, 3);
      chk("gated", 16'(n_conv), 16'h0000);
      $display("trigger test done");
      r = rnd();
      pacer_div_lo <= 16'(r[1:0] + 1);
      pacer_div_hi <= 16'(r[3:2] + 1);
      trig_src <= atp_pkg::ATP_TRIG_PACER;
      pacer_load <= 1;
      pacer_run <= 1;
      tick(1);
      pacer_load <= 0;
      n_conv = 0;
      n_pac = 0;
      tick(6300);
      chk("period", 16'(per), 16'((r[1:0] + 1) * (r[3:2] + 1) * 125));
      chk("pacer", 16'(n_conv), 16'(n_pac));
      pacer_run <= 0;
      $display("pacer test done");
      k = rnd() % 4 + 6;
      event_reload <= 16'(k);
      event_load <= 1;
      tick(1);
      event_load <= 0;
      tick(2);
      n_evt = 0;
      repeat (k + 2) u_src.pulse(1, 7);
      chk("wraps", 16'(n_evt), 16'h0001);
      chk("count", event_count, 16'(k - 2));
      u_src.g <= 2'h1;
      tick(3);
      repeat (3) u_src.pulse(1, 7);
      chk("held", event_count, 16'(k - 2));
      u_src.g <= 2'h3;
      event_clk_sel <= atp_pkg::ATP_CLK_INT_100K;
      tick(4);
      c0 = event_count;
      tick(2500);
      chk("internal", event_count, c0 - 16'h0002);
      $display("counter test done");
      repeat (6) begin
         r = rnd();
         cfg_channel <= r[3:0];
         cfg_diff <= r[4];
         cfg_write <= 1;
         pd[r[3:1]] = r[4];
         tick(1);
         cfg_write <= 0;
         tick(3);
         chk("pairs", {8'h00, pair_diff}, {8'h00, pd});
      end
      $display("config test done");
      n_conv = 0;
      sw_trigger <= 1;
      tick(1);
      sw_trigger <= 0;
      tick(3);
      chk("sw unselected", 16'(n_conv), 16'h0000);
      trig_src <= atp_pkg::ATP_TRIG_SW;
      sw_trigger <= 1;
      tick(1);
      sw_trigger <= 0;
      tick(3);
      chk("sw", 16'(n_conv), 16'h0001);
      $display("software trigger test done");
      print_verdict();
   end
endmodule
bind atp_trigger_pacer atp_trigger_pacer_properties u_chk (.sys_clk, .rst, .ext_trigger_in,
   .ext_trigger_enable_in, .trig_src, .pacer_run, .cfg_write, .pacer_out, .event_counter_out,
   .conv_start, .pair_diff);
